// ---- design/msg_queue.sv ----
// first-in first-out message queue with registered read data.
// assumes pop is only meaningful while not empty; a push while full is dropped.
`timescale 1ns/1ps
`include "status_params.svh"
module msg_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic sys_clk,
	input  wire logic srst,
	queue_if.store    q
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad
		$error("msg_queue needs DEPTH >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [CW-1:0]    count;

	// pointers wrap at DEPTH, which need not be a power of two
	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	wire do_pop  = q.pop && (count != '0);
	// newest entry is discarded when full, so older messages survive
	wire do_push = q.push && (count != CW'(DEPTH));

	assign q.empty = (count == '0);
	assign q.full  = (count == CW'(DEPTH));

	// a push in the clearing cycle survives the clear in slot zero: the set wins
	wire keep_push = q.clear && q.push;

	// storage written only on an accepted push
	always_ff @(posedge sys_clk) begin
		if (do_push || keep_push) begin
			mem[q.clear ? PW'(0) : wr_ptr] <= q.wdata;
		end
	end

	// oldest first out; reading removes the entry
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			q.rvalid <= 1'b0;
			q.rdata  <= '0;
		end else if (q.clear) begin
			wr_ptr   <= keep_push ? PW'(1) : '0;
			rd_ptr   <= '0;
			count    <= CW'(keep_push);
			q.rvalid <= 1'b0;
			q.rdata  <= '0;
		end else begin
			q.rvalid <= do_pop;
			if (do_pop) begin
				q.rdata <= mem[rd_ptr];
				rd_ptr  <= bump(rd_ptr);
			end
			if (do_push) begin
				wr_ptr <= bump(wr_ptr);
			end
			count <= count + CW'(do_push) - CW'(do_pop);
		end
	end

	property p_full_drops;
		@(posedge sys_clk) disable iff (srst)
		q.full && q.push && !q.pop && !q.clear |=> q.full && count == CW'(DEPTH);
	endproperty
	a_full_drops: assert property (p_full_drops) else $error("push into full queue changed it");

	property p_pop_shrinks;
		@(posedge sys_clk) disable iff (srst)
		!q.empty && q.pop && !q.push && !q.clear |=> q.rvalid && count == $past(count) - CW'(1);
	endproperty
	a_pop_shrinks: assert property (p_pop_shrinks) else $error("read did not remove an entry");

	c_queue_full: cover property (@(posedge sys_clk) disable iff (srst) q.full && q.push);
endmodule

// ---- design/queue_if.sv ----
// carrier between the status block and one of its message queues.
// assumes one owner (status logic) and one store (queue) per instance.
`timescale 1ns/1ps
interface queue_if #(parameter int WIDTH = 8);
	logic             push;
	logic [WIDTH-1:0] wdata;
	logic             pop;
	logic             clear;
	logic [WIDTH-1:0] rdata;
	logic             rvalid;
	logic             empty;
	logic             full;

	modport owner (output push, wdata, pop, clear, input rdata, rvalid, empty, full);
	modport store (input push, wdata, pop, clear, output rdata, rvalid, empty, full);
endinterface

// ---- design/status_params.svh ----
// constants for the status summary and service request block:
// set indices, status byte positions, reset and preset values.
// assumes nothing; included by bare name from the design files.
`ifndef STATUS_PARAMS_SVH
`define STATUS_PARAMS_SVH

// status register sets
`define NUM_SETS        7
`define SET_STD         3'h0
`define SET_OPER        3'h1
`define SET_QUES        3'h2
`define SET_MEAS        3'h3
`define SET_TRIG        3'h4
`define SET_ARM         3'h5
`define SET_SEQ         3'h6

// status byte bit positions
`define SB_MEAS         0
`define SB_EAV          2
`define SB_QUES         3
`define SB_MAV          4
`define SB_ESB          5
`define SB_RQS_MSS      6
`define SB_OPER         7

// reset and preset values
`define EN_RESET        16'h0000
`define EN_PRESET_ONES  16'hFFFF
`define PTR_RESET       16'hFFFF
`define NTR_RESET       16'h0000
`define SRE_RESET       8'h00

// queue defaults
`define OUTQ_DEPTH_DEF  16
`define OUTQ_WIDTH_DEF  8
`define ERRQ_DEPTH_DEF  10
`define ERRQ_WIDTH_DEF  16

`endif

// ---- design/status_pkg.sv ----
// types and shared helpers for the status summary block.
// assumes status_params.svh for the numbers.
package status_pkg;
	typedef logic [15:0] word_t;
	typedef logic [7:0]  byte_t;
	typedef logic [2:0]  set_sel_t;

	// masked event bits ORed into one summary message
	function automatic logic summary_of(input word_t evt, input word_t en);
		summary_of = |(evt & en);
	endfunction
endpackage

// ---- design/status_summary_srq_logic.sv ----
// status reporting: event latching, enable masks, message queues,
// status byte, service request enable and the request line.
// assumes command strobes are one-cycle pulses from a command decoder.
//
// Operation
// - enable bit zero masks its event bit
// - reading an enable register changes nothing
// - power-up clears every enable register
// - preset clears operation, questionable, measurement enables
// - preset sets trigger, arm, sequence enables
// - writing zero clears standard event enable
// - output queue is FIFO driving MAV
// - error queue holds ten messages FIFO
// - error queue enqueue sets EAV, empty clears
// - summary status byte bits mirror sources
// - bit six is MSS on query, RQS on poll
// - status byte query changes no bit
// - poll clears RQS, MSS stays while enabled
// - power-up clears status byte; clear status clears every bit but MAV
// - bit six ORs summaries masked by enables
// - request enable cleared only by reset or zero
// - enabled summary rising edge sets RQS, SRQ
// - after poll same event may request again
// - event bits latch until read or cleared
// - masked events ORed into one summary
// - event set by filtered condition transitions
`timescale 1ns/1ps
`include "status_params.svh"
module status_summary_srq_logic #(
	parameter int OUTQ_DEPTH = `OUTQ_DEPTH_DEF,
	parameter int OUTQ_WIDTH = `OUTQ_WIDTH_DEF,
	parameter int ERRQ_DEPTH = `ERRQ_DEPTH_DEF,
	parameter int ERRQ_WIDTH = `ERRQ_WIDTH_DEF
) (
	input  wire logic                         sys_clk,
	input  wire logic                         srst,
	input  wire logic [`NUM_SETS-1:0][15:0]   cond_in,
	input  wire logic [7:0]                   std_evt_set,
	input  wire logic [2:0]                   reg_sel,
	input  wire logic [15:0]                  wr_data,
	input  wire logic                         en_wr,
	input  wire logic                         ptr_wr,
	input  wire logic                         ntr_wr,
	input  wire logic                         en_rd,
	input  wire logic                         evt_rd,
	input  wire logic                         sre_rd,
	output logic      [15:0]                  rd_data,
	output logic                              rd_valid,
	input  wire logic                         status_preset,
	input  wire logic                         clear_status,
	input  wire logic                         sre_wr,
	input  wire logic [7:0]                   sre_data,
	input  wire logic                         stb_query,
	input  wire logic                         serial_poll,
	output logic      [7:0]                   stb_data,
	output logic                              stb_valid,
	input  wire logic                         outq_push,
	input  wire logic [OUTQ_WIDTH-1:0]        outq_data,
	output logic                              outq_full,
	input  wire logic                         outq_pop,
	output logic      [OUTQ_WIDTH-1:0]        outq_rdata,
	output logic                              outq_rvalid,
	input  wire logic                         errq_push,
	input  wire logic [ERRQ_WIDTH-1:0]        errq_data,
	output logic                              errq_full,
	input  wire logic                         errq_pop,
	output logic      [ERRQ_WIDTH-1:0]        errq_rdata,
	output logic                              errq_rvalid,
	output logic                              mss,
	output logic                              rqs,
	output logic                              srq
);
	if (OUTQ_DEPTH < 2 || ERRQ_DEPTH < 2 || OUTQ_WIDTH < 1 || ERRQ_WIDTH < 1) begin : g_bad
		$error("queue depths must be at least 2 and widths at least 1");
	end

	logic [`NUM_SETS-1:0][15:0] en;
	logic [`NUM_SETS-1:0][15:0] evt;
	logic [`NUM_SETS-1:0][15:0] ptr;
	logic [`NUM_SETS-1:0][15:0] ntr;
	logic [`NUM_SETS-1:0][15:0] prev_cond;
	logic [7:0]                 sre;
	logic [7:0]                 prev_enabled;
	logic [`NUM_SETS-1:0]       fresh_hit;

	queue_if #(.WIDTH(OUTQ_WIDTH)) outq ();
	queue_if #(.WIDTH(ERRQ_WIDTH)) errq ();

	// response messages; the queue keeps its data across clear status
	msg_queue #(.WIDTH(OUTQ_WIDTH), .DEPTH(OUTQ_DEPTH)) u_outq (
		.sys_clk (sys_clk),
		.srst    (srst),
		.q       (outq.store)
	);

	// error and status messages, emptied by clear status
	msg_queue #(.WIDTH(ERRQ_WIDTH), .DEPTH(ERRQ_DEPTH)) u_errq (
		.sys_clk (sys_clk),
		.srst    (srst),
		.q       (errq.store)
	);

	// queue hookup
	assign outq.push   = outq_push;
	assign outq.wdata  = outq_data;
	assign outq.pop    = outq_pop;
	assign outq.clear  = 1'b0;
	assign errq.push   = errq_push;
	assign errq.wdata  = errq_data;
	assign errq.pop    = errq_pop;
	assign errq.clear  = clear_status;
	assign outq_full   = outq.full;
	assign outq_rdata  = outq.rdata;
	assign outq_rvalid = outq.rvalid;
	assign errq_full   = errq.full;
	assign errq_rdata  = errq.rdata;
	assign errq_rvalid = errq.rvalid;

	// selection of the addressed set; unknown selects touch nothing
	wire sel_ok = (reg_sel < 3'(`NUM_SETS));

	// summaries of each set; sets 1 and 4..6 feed the operation summary
	logic [`NUM_SETS-1:0] set_sum;
	always_comb begin
		for (int s = 0; s < `NUM_SETS; s++) begin
			set_sum[s] = status_pkg::summary_of(evt[s], en[s]);
		end
	end
	wire oper_sum = set_sum[`SET_OPER] | set_sum[`SET_TRIG] | set_sum[`SET_ARM]
	              | set_sum[`SET_SEQ];

	// status byte summary bits are live wires, never latched
	logic [7:0] summary_byte;
	always_comb begin
		summary_byte              = 8'h00;
		summary_byte[`SB_MEAS]    = set_sum[`SET_MEAS];
		summary_byte[`SB_EAV]     = !errq.empty;
		summary_byte[`SB_QUES]    = set_sum[`SET_QUES];
		summary_byte[`SB_MAV]     = !outq.empty;
		summary_byte[`SB_ESB]     = set_sum[`SET_STD];
		summary_byte[`SB_OPER]    = oper_sum;
	end

	// master summary; a request follows an enabled summary rising or a fresh event
	wire [7:0] enabled_sum = summary_byte & sre;
	wire [7:0] fresh_byte  = {fresh_hit[`SET_OPER] | fresh_hit[`SET_TRIG] | fresh_hit[`SET_ARM]
	                         | fresh_hit[`SET_SEQ], 1'b0, fresh_hit[`SET_STD], 1'b0,
	                         fresh_hit[`SET_QUES], 2'b00, fresh_hit[`SET_MEAS]};
	assign mss = |enabled_sum;
	wire rise = (|(enabled_sum & ~prev_enabled)) || (|(fresh_byte & sre));

	// per-set bookkeeping: enables, filters and latched events
	always_ff @(posedge sys_clk) begin
		for (int s = 0; s < `NUM_SETS; s++) begin
			// a repeat of a still-latched event must be able to request again
			fresh_hit[s] <= !srst && (|(next_evt_bits(s) & en[s]));
			if (srst) begin
				en[s]        <= `EN_RESET;
				ptr[s]       <= `PTR_RESET;
				ntr[s]       <= `NTR_RESET;
				prev_cond[s] <= 16'h0000;
				evt[s]       <= 16'h0000;
			end else begin
				prev_cond[s] <= cond_in[s];
				if (status_preset) begin
					ptr[s] <= `PTR_RESET;
					ntr[s] <= `NTR_RESET;
					if (s == `SET_TRIG || s == `SET_ARM || s == `SET_SEQ) begin
						en[s] <= `EN_PRESET_ONES;
					end else if (s != `SET_STD) begin
						en[s] <= `EN_RESET;
					end
				end else begin
					if (en_wr && sel_ok && reg_sel == 3'(s)) begin
						// standard set has eight bits; a zero write clears it
						en[s] <= (s == `SET_STD) ? {8'h00, wr_data[7:0]} : wr_data;
					end
					if (ptr_wr && sel_ok && reg_sel == 3'(s)) begin
						ptr[s] <= wr_data;
					end
					if (ntr_wr && sel_ok && reg_sel == 3'(s)) begin
						ntr[s] <= wr_data;
					end
				end
				// a fresh event in the clearing cycle survives the clear
				evt[s] <= (clear_status || (evt_rd && reg_sel == 3'(s)))
				          ? next_evt_bits(s) : (evt[s] | next_evt_bits(s));
			end
		end
	end

	// newly detected events: filtered transitions, or pulses for the standard set
	function automatic logic [15:0] next_evt_bits(input int s);
		logic [15:0] up;
		logic [15:0] down;
		up   = cond_in[s] & ~prev_cond[s];
		down = ~cond_in[s] & prev_cond[s];
		if (s == `SET_STD) begin
			next_evt_bits = {8'h00, std_evt_set};
		end else begin
			next_evt_bits = (up & ptr[s]) | (down & ntr[s]);
		end
	endfunction

	// register reads return data a cycle later; an event read clears that set, other reads alter nothing
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= en_rd || evt_rd || sre_rd;
			if (sre_rd) begin
				rd_data <= {8'h00, sre};
			end else if (en_rd && sel_ok) begin
				rd_data <= en[reg_sel];
			end else if (evt_rd && sel_ok) begin
				rd_data <= evt[reg_sel];
			end else begin
				rd_data <= 16'h0000;
			end
		end
	end

	// service request enable: only reset or a write changes it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sre <= `SRE_RESET;
		end else if (sre_wr) begin
			sre <= {sre_data[7], 1'b0, sre_data[5:0]}; // bit six cannot be enabled
		end
	end

	// rqs: rising edge sets it and wins over a poll or clear in the same cycle;
	// the enabled history is re-armed every cycle, so after a poll a new
	// rising edge of the same source can request again
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rqs          <= 1'b0;
			prev_enabled <= 8'h00;
		end else begin
			prev_enabled <= enabled_sum;
			if (rise) begin
				rqs <= 1'b1;
			end else if (serial_poll || clear_status || !mss) begin
				rqs <= 1'b0;
			end
		end
	end

	// line released as soon as no enabled summary remains
	assign srq = rqs && mss;

	// status byte answers: poll reports rqs and clears it, query reports mss and leaves state alone
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stb_data  <= 8'h00;
			stb_valid <= 1'b0;
		end else begin
			stb_valid <= serial_poll || stb_query;
			if (serial_poll) begin
				stb_data <= summary_byte | {1'b0, rqs, 6'h00};
			end else if (stb_query) begin
				stb_data <= summary_byte | {1'b0, mss, 6'h00};
			end
		end
	end

	property p_en_read_stable;
		@(posedge sys_clk) disable iff (srst)
		en_rd && !en_wr && !status_preset |=> en == $past(en) && rd_valid;
	endproperty
	a_en_read_stable: assert property (p_en_read_stable) else $error("enable read changed it");

	property p_reset_clears;
		@(posedge sys_clk) srst |=> en == '0 && sre == 8'h00 && !rqs && stb_data == 8'h00;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset left state set");

	property p_preset_clears;
		@(posedge sys_clk) disable iff (srst)
		status_preset |=> en[`SET_OPER] == 16'h0000 && en[`SET_QUES] == 16'h0000
		                  && en[`SET_MEAS] == 16'h0000;
	endproperty
	a_preset_clears: assert property (p_preset_clears) else $error("preset left enable set");

	property p_preset_sets;
		@(posedge sys_clk) disable iff (srst)
		status_preset |=> en[`SET_TRIG] == 16'hFFFF && en[`SET_ARM] == 16'hFFFF
		                  && en[`SET_SEQ] == 16'hFFFF;
	endproperty
	a_preset_sets: assert property (p_preset_sets) else $error("preset did not fill enables");

	property p_rise_requests;
		@(posedge sys_clk) disable iff (srst)
		rise |=> rqs ##0 (srq || !mss);
	endproperty
	a_rise_requests: assert property (p_rise_requests) else $error("rising summary gave no request");

	property p_poll_clears_rqs;
		@(posedge sys_clk) disable iff (srst)
		serial_poll && !rise |=> !rqs && !srq && stb_valid && stb_data[6] == $past(rqs);
	endproperty
	a_poll_clears_rqs: assert property (p_poll_clears_rqs) else $error("poll did not clear rqs");

	property p_query_reports_mss;
		@(posedge sys_clk) disable iff (srst)
		stb_query && !serial_poll && !clear_status |=> stb_data[6] == $past(mss)
		                                           && (rqs || !$past(rqs) || !$past(mss));
	endproperty
	a_query_reports_mss: assert property (p_query_reports_mss) else $error("query answer wrong");

	property p_mav_follows_push;
		@(posedge sys_clk) disable iff (srst)
		outq_push && !outq.full |=> summary_byte[`SB_MAV];
	endproperty
	a_mav_follows_push: assert property (p_mav_follows_push) else $error("MAV not set");

	property p_event_latches;
		@(posedge sys_clk) disable iff (srst)
		!clear_status && !evt_rd |=> (evt & $past(evt)) == $past(evt);
	endproperty
	a_event_latches: assert property (p_event_latches) else $error("event bit dropped");

	property p_masked_no_status;
		@(posedge sys_clk) disable iff (srst)
		summary_byte[`SB_MEAS] == |(evt[`SET_MEAS] & en[`SET_MEAS]);
	endproperty
	a_masked_no_status: assert property (p_masked_no_status) else $error("masked event leaked");

	c_srq_raised: cover property (@(posedge sys_clk) disable iff (srst) rise ##1 srq);
	c_poll_hit:   cover property (@(posedge sys_clk) disable iff (srst) rqs && serial_poll);
	c_rerequest:  cover property (@(posedge sys_clk) disable iff (srst) serial_poll ##[1:20] rise);
	c_preset:     cover property (@(posedge sys_clk) disable iff (srst) status_preset);
endmodule

// ---- test/bus_ctrl_model.sv ----
// behavioural bus controller: status byte query, serial poll, message fetch.
// assumes strobes are sampled at the rising edge and answered one cycle later.
`timescale 1ns/1ps
module bus_ctrl_model (
	input  wire logic              sys_clk,
	output logic                   stb_query,
	output logic                   serial_poll,
	output logic                   outq_pop,
	output logic                   errq_pop,
	input  wire status_pkg::byte_t stb_data,
	input  wire logic              stb_valid,
	input  wire status_pkg::byte_t outq_rdata,
	input  wire logic              outq_rvalid,
	input  wire status_pkg::word_t errq_rdata,
	input  wire logic              errq_rvalid
);
	// idle bus: no query, no talker addressed
	initial begin
		stb_query = 1'b0;
		serial_poll = 1'b0;
		outq_pop = 1'b0;
		errq_pop = 1'b0;
	end

	// one status byte read; a missing answer comes back unknown so it never matches
	task automatic read_stb(input bit poll, output status_pkg::byte_t b);
		@(negedge sys_clk);
		stb_query = !poll;
		serial_poll = poll;
		@(negedge sys_clk);
		stb_query = 1'b0;
		serial_poll = 1'b0;
		b = stb_valid ? stb_data : 'x;
	endtask

	// query already sent, so the pop stands for addressing the device to talk
	task automatic fetch(input bit err, output status_pkg::word_t d);
		@(negedge sys_clk);
		errq_pop = err;
		outq_pop = !err;
		@(negedge sys_clk);
		errq_pop = 1'b0;
		outq_pop = 1'b0;
		if (err)
			d = errq_rvalid ? errq_rdata : 'x;
		else
			d = outq_rvalid ? {8'h00, outq_rdata} : 'x;
	endtask
endmodule

// ---- test/status_summary_srq_logic_tb_top.sv ----
// self-checking bench for the status summary and service request block.
// assumes bus_ctrl_model as the controller and the design's default widths.
`timescale 1ns/1ps
`include "status_params.svh"
module status_summary_srq_logic_tb_top;
	typedef enum int {s_en_wr, s_ptr_wr, s_ntr_wr, s_en_rd, s_evt_rd, s_sre_rd,
		s_preset, s_cls, s_sre_wr, s_out_push, s_err_push} strobe_t;

	logic                       sys_clk = 1'b0;
	logic                       srst;
	logic [`NUM_SETS-1:0][15:0] cond;
	logic [7:0]                 std_evt;
	logic [2:0]                 reg_sel;
	status_pkg::word_t          wr_data;
	logic [10:0]                strb;
	status_pkg::word_t          rd_data;
	status_pkg::byte_t          stb_data;
	status_pkg::byte_t          outq_rdata;
	status_pkg::word_t          errq_rdata;
	logic rd_valid, stb_valid, outq_full, outq_rvalid, errq_full, errq_rvalid;
	logic mss, rqs, srq, stb_query, serial_poll, outq_pop, errq_pop;
	int                         n_errors = 0;
	int                         check_count = 0;
	int                         s;
	status_pkg::word_t          d;
	status_pkg::word_t          got;
	status_pkg::byte_t          b;
	status_pkg::word_t          q [11];

	always #25 sys_clk = ~sys_clk;

	status_summary_srq_logic i_dut (
		.sys_clk(sys_clk), .srst(srst), .cond_in(cond), .std_evt_set(std_evt),
		.reg_sel(reg_sel), .wr_data(wr_data), .en_wr(strb[s_en_wr]),
		.ptr_wr(strb[s_ptr_wr]), .ntr_wr(strb[s_ntr_wr]), .en_rd(strb[s_en_rd]),
		.evt_rd(strb[s_evt_rd]), .sre_rd(strb[s_sre_rd]), .rd_data(rd_data),
		.rd_valid(rd_valid), .status_preset(strb[s_preset]), .clear_status(strb[s_cls]),
		.sre_wr(strb[s_sre_wr]), .sre_data(wr_data[7:0]), .stb_query(stb_query),
		.serial_poll(serial_poll), .stb_data(stb_data), .stb_valid(stb_valid),
		.outq_push(strb[s_out_push]), .outq_data(wr_data[7:0]), .outq_full(outq_full),
		.outq_pop(outq_pop), .outq_rdata(outq_rdata), .outq_rvalid(outq_rvalid),
		.errq_push(strb[s_err_push]), .errq_data(wr_data), .errq_full(errq_full),
		.errq_pop(errq_pop), .errq_rdata(errq_rdata), .errq_rvalid(errq_rvalid),
		.mss(mss), .rqs(rqs), .srq(srq)
	);

	bus_ctrl_model bus (
		.sys_clk(sys_clk), .stb_query(stb_query), .serial_poll(serial_poll),
		.outq_pop(outq_pop), .errq_pop(errq_pop), .stb_data(stb_data),
		.stb_valid(stb_valid), .outq_rdata(outq_rdata), .outq_rvalid(outq_rvalid),
		.errq_rdata(errq_rdata), .errq_rvalid(errq_rvalid)
	);

	// the standard set only keeps its low byte
	function automatic status_pkg::word_t en_exp(input logic [2:0] sel, input status_pkg::word_t v);
		return (sel == 3'h0) ? {8'h00, v[7:0]} : v;
	endfunction

	function automatic status_pkg::word_t req_lines();
		return {13'h0000, rqs, srq, mss};
	endfunction

	task automatic close_out();
		if (n_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input status_pkg::word_t g, input status_pkg::word_t e);
		check_count++;
		if (g !== e) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			n_errors++;
		end
	endtask

	// one-cycle strobe; select and data stand with it
	task automatic op(input int i, input logic [2:0] sel, input status_pkg::word_t v);
		@(negedge sys_clk);
		reg_sel = sel;
		wr_data = v;
		strb[i] = 1'b1;
		@(negedge sys_clk);
		strb = '0;
	endtask

	task automatic rd(input int i, input logic [2:0] sel, input status_pkg::word_t e);
		op(i, sel, 16'h0000);
		chk(rd_valid ? rd_data : 'x, e);
	endtask

	task automatic sb(input bit poll, input status_pkg::byte_t e);
		bus.read_stb(poll, b);
		chk({8'h00, b}, {8'h00, e});
	endtask

	// one standard event, then a cycle for the request register to follow
	task automatic evt(input logic [7:0] m);
		@(negedge sys_clk);
		std_evt = m;
		@(negedge sys_clk);
		std_evt = '0;
		@(negedge sys_clk);
	endtask

	initial begin
		srst = 1'b1;
		cond = '0;
		std_evt = '0;
		reg_sel = '0;
		wr_data = '0;
		strb = '0;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		srst = 1'b0;
		void'($urandom(32'he490));
		for (s = 0; s < 7; s++)
			rd(s_en_rd, s[2:0], 16'h0000);
		rd(s_sre_rd, 3'h0, 16'h0000);
		sb(1'b0, 8'h00);
		for (s = 0; s < 7; s++) begin
			d = 16'($urandom);
			op(s_en_wr, s[2:0], d);
			rd(s_en_rd, s[2:0], en_exp(s[2:0], d));
			rd(s_en_rd, s[2:0], en_exp(s[2:0], d));
		end
		op(s_preset, 3'h0, 16'h0000);
		for (s = 1; s < 7; s++)
			rd(s_en_rd, s[2:0], s < 4 ? 16'h0000 : 16'hffff);
		op(s_en_wr, 3'h0, 16'h00ff);
		op(s_en_wr, 3'h0, 16'h0000);
		rd(s_en_rd, 3'h0, 16'h0000);
		// standard event summary through to the request line
		op(s_en_wr, 3'h0, 16'h0020);
		d = 16'($urandom);
		op(s_sre_wr, 3'h0, d);
		rd(s_sre_rd, 3'h0, d & 16'h00bf);
		rd(s_sre_rd, 3'h0, d & 16'h00bf);
		op(s_sre_wr, 3'h0, 16'h0020);
		evt(8'h20);
		chk(req_lines(), 16'h0007);
		sb(1'b0, 8'h60);
		sb(1'b0, 8'h60);
		sb(1'b1, 8'h60);
		chk(req_lines(), 16'h0001);
		sb(1'b1, 8'h20);
		// same event again while its event bit is still latched
		evt(8'h20);
		chk(req_lines(), 16'h0007);
		sb(1'b1, 8'h60);
		rd(s_evt_rd, 3'h0, 16'h0020);
		sb(1'b0, 8'h00);
		evt(8'h20);
		chk(req_lines(), 16'h0007);
		op(s_sre_wr, 3'h0, 16'h0000);
		rd(s_sre_rd, 3'h0, 16'h0000);
		sb(1'b1, 8'h20);
		op(s_en_wr, 3'h0, 16'h0000);
		sb(1'b0, 8'h00);
		// rise caught by the positive filter, fall by the negative one
		op(s_en_wr, 3'h3, 16'h0003);
		op(s_ptr_wr, 3'h3, 16'h0001);
		op(s_ntr_wr, 3'h3, 16'h0002);
		cond[3] = 16'h0003;
		repeat (2) @(negedge sys_clk);
		sb(1'b0, 8'h01);
		rd(s_evt_rd, 3'h3, 16'h0001);
		sb(1'b0, 8'h00);
		cond[3] = 16'h0000;
		repeat (2) @(negedge sys_clk);
		rd(s_evt_rd, 3'h3, 16'h0002);
		// eleven pushes into ten places: the newest is the one lost
		for (s = 0; s < 11; s++) begin
			q[s] = 16'($urandom);
			op(s_err_push, 3'h0, q[s]);
		end
		chk({15'h0000, errq_full}, 16'h0001);
		sb(1'b0, 8'h04);
		for (s = 0; s < 10; s++) begin
			bus.fetch(1'b1, got);
			chk(got, q[s]);
		end
		sb(1'b0, 8'h00);
		d = 16'($urandom);
		op(s_out_push, 3'h0, d);
		op(s_out_push, 3'h0, ~d);
		op(s_err_push, 3'h0, d);
		sb(1'b0, 8'h14);
		op(s_cls, 3'h0, 16'h0000);
		sb(1'b0, 8'h10);
		bus.fetch(1'b0, got);
		chk(got, {8'h00, d[7:0]});
		sb(1'b0, 8'h10);
		bus.fetch(1'b0, got);
		chk(got, {8'h00, ~d[7:0]});
		sb(1'b0, 8'h00);
		// one push more than the output queue holds, then drain in order
		for (s = 0; s < `OUTQ_DEPTH_DEF + 1; s++)
			op(s_out_push, 3'h0, d + 16'(s));
		chk({15'h0000, outq_full}, 16'h0001);
		for (s = 0; s < `OUTQ_DEPTH_DEF; s++) begin
			bus.fetch(1'b0, got);
			chk(got, {8'h00, 8'(d + 16'(s))});
		end
		chk({15'h0000, outq_full}, 16'h0000);
		sb(1'b0, 8'h00);
		close_out();
	end

	// the sequence needs well under a thousand cycles; five thousand means a hang
	initial begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		close_out();
	end
endmodule
